// *** design/bbdp_ctrl.sv ***
// control logic of a six-string backlight boost driver
// Overview of operation
// R1: hold everything off until supply passes lockout; hysteresis before locking out again.
// R2: after enable, switching never starts while overvoltage sense is below 70mV.
// R3: start boosting through soft-start only when lockout and over-temperature checks pass.
// R4: host raises enable only after supply and dimming PWM are established; tb_top raises enable before the supply comparators.
// R5: each switching cycle starts with the switch on, at least 100ns.
// R6: peak-current comparator trip turns the switch off within the cycle.
// R7: feedback is the lowest sink pin among active strings.
// R8: light load gives one minimum pulse, then switch off until boosting needed.
// R9: mode input high selects combined analog and PWM dimming, 25% transfer.
// R10: combined mode, duty at or above 25%: amplitude equals set current times duty.
// R11: combined mode, duty below 25%: amplitude 25%, output duty four times input.
// R12: output dimming waveform runs at 24kHz to 27.5kHz for any input rate.
// R13: mode input low: full set current, strings gated directly by the PWM.
// R14: overvoltage trip stops switching; resume when below recovery threshold.
// R15: switching only while overvoltage sense stays above 70mV.
// R16: overvoltage trip marks off strings whose sink pin is below 260mV.
// R17: marked strings leave regulation and return once reconnected.
// R18: all six strings open: regulator off until supply or enable cycles; an over-temperature shutdown also releases the latch here.
// R19: sink pin above 5.5V flags a short on that string.
// R20: short lasting over 1.6ms disables the string; restored when short clears.
// R21: short timer counts switching cycles at 1.25MHz.
// R22: open-drain fault flag pulled low in any fault mode.
// R23: over-temperature shuts down; recover below lower hysteresis threshold.
// R24: duty measured by counting high time against period, updated each period.
// R25: PWM, enable and mode inputs pass two-flop synchronisers before use.
module bbdp_ctrl import bbdp_pkg::*; #(
   parameter int N_STR   = 6,
   parameter int LEVEL_W = 8,
   parameter int IDLE_CYC = PWM_IDLE_CYC
) (
   input  wire logic                     clock,
   input  wire logic                     rst_b,
   input  wire logic                     enable_in,
   input  wire logic                     dimming_pwm_input,
   input  wire logic                     mode_select,
   input  wire logic                     supply_above_rise,
   input  wire logic                     supply_above_fall,
   input  wire logic                     temp_above_high,
   input  wire logic                     temp_above_low,
   input  wire logic                     overvoltage_sense_trip,
   input  wire logic                     overvoltage_sense_above_recover,
   input  wire logic                     overvoltage_sense_above_short,
   input  wire logic                     peak_trip,
   input  wire logic                     boost_demand,
   input  wire logic [N_STR-1:0]         string_sink_pin_open,
   input  wire logic [N_STR-1:0]         string_sink_pin_short,
   input  wire logic [N_STR*LEVEL_W-1:0] string_sink_pin_level,
   input  wire logic [3:0]               avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [3:0]               avs_byteenable,
   input  wire logic [31:0]              avs_writedata,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest,
   output logic                          switch_gate,
   output logic [7:0]                    soft_start_level,
   output logic [DUTY_W-1:0]             set_current_scale,
   output logic [N_STR-1:0]              string_gate,
   output logic [N_STR-1:0]              feedback_select,
   output logic                          fault_flag_out,
   output logic                          fault_flag_oe
);
   typedef struct packed {
      logic [1:0]                pwm_s;
      logic [1:0]                en_s;
      logic [1:0]                mode_s;
      bbdp_state_t               state;
      logic                      uvlo_ok;
      logic                      hot;
      logic                      ovp_stop;
      logic [SW_W-1:0]           sw_cnt;
      logic                      sw_on;
      logic [SW_W-1:0]           on_cnt;
      logic                      skip_pulse;
      logic                      skipped;
      logic [15:0]               ss_div;
      logic [7:0]                ss_level;
      logic                      pwm_prev;
      logic                      seen;
      logic [MEAS_W-1:0]         hi_cnt;
      logic [MEAS_W-1:0]         per_cnt;
      logic [DUTY_W-1:0]         duty;
      logic [DUTY_W-1:0]         amp;
      logic [DIM_W-1:0]          dim_cnt;
      logic [DIM_W-1:0]          dim_on;
      logic                      dim_full;
      logic [N_STR-1:0]          marked;
      logic [N_STR-1:0]          shorted;
      logic [N_STR-1:0][SC_W-1:0] sc_cnt;
      logic [N_STR-1:0]          fb_sel;
      logic [N_STR-1:0]          gate;
      logic                      fault;
      logic                      av_wait;
      logic [31:0]               av_rdata;
      logic [15:0]               ss_cfg;
   } bbdp_ctrl_state_t;

   bbdp_ctrl_state_t s, next_s;
   logic [1:0]        rst_q;
   logic              srst_b;
   logic              div_go;
   logic              div_done;
   logic [DUTY_W-1:0] div_quot;

   // one-hot pick of the lowest level among the active strings
   function automatic logic [N_STR-1:0] lowest_sel(input logic [N_STR*LEVEL_W-1:0] lv,
                                                    input logic [N_STR-1:0]         act);
      logic [N_STR-1:0]   sel;
      logic [LEVEL_W-1:0] best;
      sel  = '0;
      best = '1;
      for (int i = 0; i < N_STR; i++) begin
         if (act[i] && (sel == '0 || lv[i*LEVEL_W +: LEVEL_W] < best)) begin
            sel  = N_STR'(1) << i;
            best = lv[i*LEVEL_W +: LEVEL_W];
         end
      end
      return sel;
   endfunction : lowest_sel

   ////////////////////////////////////////////////////////////////////////////
   // reset release
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign srst_b = rst_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // duty divider
   bbdp_div #(.NUM_W(MEAS_W), .Q_W(DUTY_W)) u_div (
      .clock  (clock),
      .srst_b (srst_b),
      .start  (div_go),
      .num    (s.hi_cnt),
      .den    (s.per_cnt),
      .done   (div_done),
      .quot   (div_quot)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic             pwm;
      logic             rise;
      logic             idle;
      logic             running;
      logic             can_sw;
      logic             sw_tick;
      logic             trip_evt;
      logic             dim_gate;
      logic [N_STR-1:0] newly_open;
      logic [N_STR-1:0] act;
      logic [19:0]      dim_prod;
      pwm        = s.pwm_s[1];
      rise       = pwm & ~s.pwm_prev;
      idle       = s.per_cnt >= MEAS_W'(IDLE_CYC);
      running    = (s.state == ST_SOFT) || (s.state == ST_RUN);
      sw_tick    = s.sw_cnt == '0;
      trip_evt   = overvoltage_sense_trip && !s.ovp_stop && running;
      newly_open = string_sink_pin_open & ~s.marked;
      act        = ~(s.marked | s.shorted);
      dim_prod   = 20'h0;
      can_sw     = 1'b0;
      dim_gate   = 1'b0;
      div_go     = rise && s.seen && !idle;
      next_s     = s;

      next_s.pwm_s  = {s.pwm_s[0], dimming_pwm_input};  // see R25
      next_s.en_s   = {s.en_s[0], enable_in};          // see R25
      next_s.mode_s = {s.mode_s[0], mode_select};      // see R25

      // comparator hysteresis latches
      if (supply_above_rise) next_s.uvlo_ok = 1'b1;    // see R1
      else if (!supply_above_fall) next_s.uvlo_ok = 1'b0;
      if (temp_above_high) next_s.hot = 1'b1;           // see R23
      else if (!temp_above_low) next_s.hot = 1'b0;
      if (overvoltage_sense_trip) next_s.ovp_stop = 1'b1; // see R14
      else if (!overvoltage_sense_above_recover) next_s.ovp_stop = 1'b0;

      // start-up and shutdown sequence
      unique case (s.state)
         ST_OFF: begin
            next_s.ss_level = '0;
            if (s.en_s[1] && s.uvlo_ok && !s.hot) next_s.state = ST_QUAL; // see R3
         end
         ST_QUAL: begin
            next_s.ss_level = '0;
            next_s.ss_div   = '0;
            if (overvoltage_sense_above_short) next_s.state = ST_SOFT; // see R2
         end
         ST_SOFT: begin
            next_s.ss_div = s.ss_div + 16'h1;
            if (s.ss_div >= s.ss_cfg) begin                  // see R3
               next_s.ss_div   = '0;
               next_s.ss_level = s.ss_level + 8'h1;
               if (s.ss_level == SS_TOP - 8'h1) next_s.state = ST_RUN;
            end
         end
         ST_RUN: next_s.ss_level = SS_TOP;
         ST_LATCH: next_s.ss_level = '0;
      endcase
      if (trip_evt && ((s.marked | newly_open) == '1)) next_s.state = ST_LATCH; // see R18
      if (!s.en_s[1] || !s.uvlo_ok || s.hot) next_s.state = ST_OFF; // see R1 see R23

      // string mark-off; the set wins over reconnect
      next_s.marked = s.marked & string_sink_pin_open;              // see R17
      if (trip_evt && next_s.state != ST_LATCH) begin
         next_s.marked = next_s.marked | newly_open;                // see R16
      end
      if (s.state == ST_OFF) next_s.marked = '0;

      // short-string timers on switching cycles
      for (int i = 0; i < N_STR; i++) begin
         if (!string_sink_pin_short[i]) begin                       // see R19
            next_s.sc_cnt[i]  = '0;
            next_s.shorted[i] = 1'b0;                               // see R20
         end else if (sw_tick) begin                                // see R21
            if (s.sc_cnt[i] == SC_W'(SHORT_SW_CYC)) next_s.shorted[i] = 1'b1; // see R20
            else next_s.sc_cnt[i] = s.sc_cnt[i] + SC_W'(1);
         end
      end

      next_s.fb_sel = lowest_sel(string_sink_pin_level, act);      // see R7

      // switching cycle
      can_sw = running && !s.ovp_stop && !overvoltage_sense_trip
               && overvoltage_sense_above_short;                    // see R14 see R15
      next_s.sw_cnt = (s.sw_cnt == SW_W'(SW_PER_CYC - 1)) ? '0 : s.sw_cnt + SW_W'(1);
      if (!can_sw) begin
         next_s.sw_on = 1'b0;
      end else if (sw_tick && (boost_demand || !s.skipped)) begin
         next_s.sw_on      = 1'b1;                                  // see R5
         next_s.on_cnt     = SW_W'(1);
         next_s.skip_pulse = !boost_demand;                         // see R8
         next_s.skipped    = !boost_demand;
      end else if (s.sw_on) begin
         if (s.on_cnt >= SW_W'(MIN_ON_CYC) && (peak_trip || s.skip_pulse)) begin
            next_s.sw_on = 1'b0;                                    // see R6 see R8
         end else if (s.sw_cnt == SW_W'(SW_PER_CYC - 1)) begin
            next_s.sw_on = 1'b0;
         end else begin
            next_s.on_cnt = s.on_cnt + SW_W'(1);
         end
      end
      if (boost_demand) next_s.skipped = 1'b0;

      // input duty measurement
      next_s.pwm_prev = pwm;
      if (rise) begin
         next_s.seen    = 1'b1;                                     // see R24
         next_s.hi_cnt  = MEAS_W'(1);
         next_s.per_cnt = MEAS_W'(1);
      end else begin
         if (!idle) next_s.per_cnt = s.per_cnt + MEAS_W'(1);
         if (pwm && !idle) next_s.hi_cnt = s.hi_cnt + MEAS_W'(1);
      end
      if (idle && !rise) begin
         next_s.seen = 1'b0;
         next_s.duty = pwm ? DUTY_W'(DUTY_FULL) : '0;
      end
      if (div_done) next_s.duty = div_quot;                         // see R24

      // amplitude and regenerated dimming duty
      if (!s.mode_s[1]) begin
         next_s.amp      = DUTY_W'(DUTY_FULL);                      // see R13
         next_s.dim_full = 1'b1;
      end else if (s.duty >= DUTY_W'(DUTY_XFER)) begin             // see R9
         next_s.amp      = s.duty;                                  // see R10
         next_s.dim_full = 1'b1;
      end else begin
         dim_prod        = 20'(s.duty) * 20'(DIM_PER_CYC * LOW_DUTY_MULT);
         next_s.amp      = DUTY_W'(DUTY_XFER);                      // see R11
         next_s.dim_full = 1'b0;
         next_s.dim_on   = DIM_W'(dim_prod >> DUTY_FRAC);           // see R11
      end
      next_s.dim_cnt = (s.dim_cnt == DIM_W'(DIM_PER_CYC - 1)) ? '0 : s.dim_cnt + DIM_W'(1); // see R12
      dim_gate = s.mode_s[1] ? (s.dim_full || s.dim_cnt < s.dim_on) : pwm; // see R13
      next_s.gate = (running && dim_gate) ? act : '0;               // see R17 see R20

      next_s.fault = (s.state == ST_LATCH) || s.hot || s.ovp_stop || (s.shorted != '0)
                     || (running && !overvoltage_sense_above_short); // see R22

      // bus slave, one wait state
      if ((avs_read || avs_write) && s.av_wait) begin
         next_s.av_wait = 1'b0;
         unique case (avs_address)
            REG_CONFIG: next_s.av_rdata = {16'h0, s.ss_cfg};
            REG_STATUS: next_s.av_rdata = {10'h0, s.shorted, 2'h0, s.marked, 1'b0,
                                           s.fault, s.ovp_stop, s.hot, s.uvlo_ok, s.state};
            REG_DIM:    next_s.av_rdata = {5'h0, s.amp, 5'h0, s.duty};
            default:    next_s.av_rdata = 32'h0;
         endcase
      end else begin
         next_s.av_wait = 1'b1;
      end
      if (avs_write && !s.av_wait && avs_address == REG_CONFIG) begin
         if (avs_byteenable[0]) next_s.ss_cfg[7:0] = avs_writedata[7:0];
         if (avs_byteenable[1]) next_s.ss_cfg[15:8] = avs_writedata[15:8];
      end
   end

   always_ff @(posedge clock or negedge srst_b) begin
      if (!srst_b) begin
         s         <= '0;
         s.av_wait <= 1'b1;
         s.ss_cfg  <= SS_STEP_RST;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata      = s.av_rdata;
   assign avs_waitrequest   = s.av_wait;
   assign switch_gate       = s.sw_on;
   assign soft_start_level  = s.ss_level;
   assign set_current_scale = s.amp;
   assign string_gate       = s.gate;
   assign feedback_select   = s.fb_sel;
   assign fault_flag_out    = 1'b0;
   assign fault_flag_oe     = s.fault;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [N_STR-1:0] excl;
   assign excl = s.marked | s.shorted;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!srst_b);

   sw_start_a: assert property ($rose(switch_gate) |-> s.sw_cnt == SW_W'(1)) // see R5
      else $error("switch turned on away from cycle start");
   peak_off_a: assert property (s.sw_on && s.on_cnt >= SW_W'(MIN_ON_CYC) && peak_trip
                                |=> !switch_gate) // see R6
      else $error("switch stayed on after peak trip");
   ovp_stop_a: assert property (overvoltage_sense_trip |=> !switch_gate ##1 !switch_gate) // see R14
      else $error("switching during overvoltage");
   short_out_a: assert property (!overvoltage_sense_above_short |=> !switch_gate) // see R15
      else $error("switching with output short");
   off_state_a: assert property (s.state == ST_OFF |=> !switch_gate && string_gate == '0) // see R1
      else $error("activity while off");
   latch_hold_a: assert property (s.state == ST_LATCH && s.en_s[1] && s.uvlo_ok && !s.hot
                                  |=> s.state == ST_LATCH) // see R18
      else $error("regulator latch released early");
   direct_amp_a: assert property (!s.mode_s[1] |=> set_current_scale == DUTY_W'(DUTY_FULL)) // see R13
      else $error("direct mode amplitude not full");
   gate_excl_a: assert property ((string_gate & $past(excl)) == '0) // see R17
      else $error("excluded string still gated");
   skip_hold_a: assert property (s.skipped && !boost_demand && !switch_gate
                                 |=> !switch_gate) // see R8
      else $error("pulse issued while skipping");
endmodule : bbdp_ctrl

// *** include/bbdp_pkg.sv ***
// constants and types shared by the backlight boost control block
package bbdp_pkg;
   localparam int CLK_HZ        = 10_000_000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int MIN_ON_NS     = 100;
   localparam int MIN_ON_CYC    = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SW_HZ         = 1_250_000;
   localparam int SW_PER_CYC    = CLK_HZ / SW_HZ;
   localparam int SHORT_US      = 1600;
   localparam int SHORT_SW_CYC  = SHORT_US * (SW_HZ / 1000) / 1000;
   localparam int DIM_HZ        = 25_000;
   localparam int DIM_PER_CYC   = CLK_HZ / DIM_HZ;
   localparam int PWM_MIN_HZ    = 100;
   localparam int PWM_IDLE_CYC  = CLK_HZ / PWM_MIN_HZ;
   localparam int MEAS_W        = 17;
   localparam int DUTY_FRAC     = 10;
   localparam int DUTY_W        = DUTY_FRAC + 1;
   localparam int DUTY_FULL     = 1 << DUTY_FRAC;
   localparam int TRANSFER_PCT  = 25;
   localparam int DUTY_XFER     = DUTY_FULL * TRANSFER_PCT / 100;
   localparam int LOW_DUTY_MULT = 4;
   localparam int SW_W          = 4;
   localparam int SC_W          = 12;
   localparam int DIM_W         = 9;
   localparam logic [3:0]  REG_CONFIG  = 4'h0;
   localparam logic [3:0]  REG_STATUS  = 4'h4;
   localparam logic [3:0]  REG_DIM     = 4'h8;
   localparam logic [15:0] SS_STEP_RST = 16'h0040;
   localparam logic [7:0]  SS_TOP      = 8'hFF;
   typedef enum logic [2:0] {ST_OFF, ST_QUAL, ST_SOFT, ST_RUN, ST_LATCH} bbdp_state_t;
endpackage : bbdp_pkg

// *** design/bbdp_div.sv ***
// serial fraction divider: quot = num * 2^(q_w-1) / den, num <= den
module bbdp_div import bbdp_pkg::*; #(
   parameter int NUM_W = MEAS_W,
   parameter int Q_W   = DUTY_W
) (
   input  wire logic             clock,
   input  wire logic             srst_b,
   input  wire logic             start,
   input  wire logic [NUM_W-1:0] num,
   input  wire logic [NUM_W-1:0] den,
   output logic                  done,
   output logic [Q_W-1:0]        quot
);
   typedef struct packed {
      logic           busy;
      logic           done;
      logic [4:0]     step;
      logic [NUM_W:0] rem;
      logic [NUM_W:0] den;
      logic [Q_W-1:0] quot;
   } bbdp_div_state_t;

   bbdp_div_state_t s, next_s;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      if (start) begin
         next_s.busy = 1'b1;
         next_s.step = 5'(Q_W);
         next_s.rem  = {1'b0, num};
         next_s.den  = {1'b0, den};
         next_s.quot = '0;
      end else if (s.busy) begin
         if (s.rem >= s.den) begin
            next_s.quot = s.quot | (Q_W'(1) << (s.step - 5'h1));
            next_s.rem  = (NUM_W + 1)'((s.rem - s.den) << 1);
         end else begin
            next_s.rem = (NUM_W + 1)'(s.rem << 1);
         end
         next_s.step = s.step - 5'h1;
         if (s.step == 5'h1) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge srst_b) begin
      if (!srst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;
   assign quot = s.quot;
endmodule : bbdp_div

// *** dv/bbdp_far_model.sv ***
// far-side model: host dimming source and power-stage peak comparator
module bbdp_far_model (
   input  wire logic        clock,
   input  wire logic        switch_gate,
   input  wire logic [15:0] pwm_period,
   input  wire logic [15:0] pwm_high,
   output logic             dimming_pwm_input,
   output logic             peak_trip
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] cnt = 16'h0000;
   initial begin
      dimming_pwm_input = 1'b0;
      peak_trip = 1'b0;
   end
   always @(posedge clock) begin
      cnt <= (cnt + 16'h0001 >= pwm_period) ? 16'h0000 : cnt + 16'h0001;
      // pwm runs from time zero, well before enable
      dimming_pwm_input <= (cnt < pwm_high);
      // current ramp reaches the trip level one cycle after turn-on
      peak_trip <= switch_gate;
   end
endmodule : bbdp_far_model

// *** dv/tb_top.sv ***
// top-level bench for the backlight boost control block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import bbdp_pkg::*;
   logic        clock = 1'b0, rst_b = 1'b0, enable_in = 1'b0, mode_select = 1'b1;
   logic        supply_above_rise = 1'b0, supply_above_fall = 1'b0, boost_demand = 1'b1;
   logic        temp_above_high = 1'b0, temp_above_low = 1'b0, overvoltage_sense_trip = 1'b0;
   logic        overvoltage_sense_above_recover = 1'b0, overvoltage_sense_above_short = 1'b0;
   logic        avs_read = 1'b0, avs_write = 1'b0, dimming_pwm_input, peak_trip;
   logic        avs_waitrequest, switch_gate, fault_flag_out, fault_flag_oe;
   logic [5:0]  string_sink_pin_open = 6'h00, string_sink_pin_short = 6'h00;
   logic [5:0]  string_gate, feedback_select;
   logic [47:0] string_sink_pin_level = 48'h2828_2805_140A;
   logic [3:0]  avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [7:0]  soft_start_level;
   logic [10:0] set_current_scale;
   logic [15:0] pwm_period = 16'd500, pwm_high = 16'd250;
   int          failures = 0, comparisons = 0, r, on;

   always #50 clock = ~clock;
   bbdp_far_model u_far (.clock, .switch_gate, .pwm_period, .pwm_high,
      .dimming_pwm_input, .peak_trip);
   bbdp_ctrl #(.IDLE_CYC(2000)) u_dut (.clock, .rst_b, .enable_in, .dimming_pwm_input,
      .mode_select, .supply_above_rise, .supply_above_fall, .temp_above_high,
      .temp_above_low, .overvoltage_sense_trip, .overvoltage_sense_above_recover,
      .overvoltage_sense_above_short, .peak_trip, .boost_demand, .string_sink_pin_open,
      .string_sink_pin_short, .string_sink_pin_level, .avs_address, .avs_read, .avs_write,
      .avs_byteenable(4'hF), .avs_writedata, .avs_readdata, .avs_waitrequest, .switch_gate,
      .soft_start_level, .set_current_scale, .string_gate, .feedback_select,
      .fault_flag_out, .fault_flag_oe);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      if (n >= 50) begin
         chk("bus timeout", 0, 1);
         stop_test;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask : bus

   task automatic wait_state(input logic [2:0] st);
      int n;
      n = 0;
      do begin
         bus(1'b0, REG_STATUS, 0);
         n++;
      end while (q[2:0] !== st && n < 400);
      chk("state", 32'(q[2:0]), 32'(st));
      if (q[2:0] !== st) stop_test;
   endtask : wait_state

   // counts rising edges and high cycles of switch gate (sel 0) or string 0 gate
   task automatic watch(input int sel, input int n);
      logic p, s;
      p = sel ? string_gate[0] : switch_gate;
      r = 0;
      on = 0;
      repeat (n) begin
         @(posedge clock);
         s = sel ? string_gate[0] : switch_gate;
         if (s === 1'b1 && p !== 1'b1) r++;
         if (s === 1'b1) on++;
         p = s;
      end
   endtask : watch

   ////////////////////////////////////////////////////////////////////////////////
   task automatic startup;
      bus(1'b0, REG_CONFIG, 0);
      chk("config reset", q, 32'h0000_0040);
      bus(1'b0, 4'hC, 0);
      chk("unmapped", q, 0);
      bus(1'b1, REG_CONFIG, 0);
      enable_in <= 1'b1;
      watch(0, 40);
      chk("off without supply", 32'(r), 0);
      wait_state(3'h0);
      supply_above_rise <= 1'b1;
      supply_above_fall <= 1'b1;
      wait_state(3'h1);
      supply_above_rise <= 1'b0;
      watch(0, 40);
      chk("no switch on short output", 32'(r), 0);
      overvoltage_sense_above_short <= 1'b1;
      wait_state(3'h3);
      chk("soft start top", 32'(soft_start_level), 32'h0000_00FF);
   endtask : startup

   task automatic switching;
      watch(0, 80);
      chk("cycle starts", 32'(r), 10);
      chk("on time", 32'(on >= r * MIN_ON_CYC && on <= r * (SW_PER_CYC - 1)), 1);
      boost_demand <= 1'b0;
      watch(0, 16);
      watch(0, 80);
      chk("pulse skip", 32'(r), 0);
      boost_demand <= 1'b1;
   endtask : switching

   task automatic dimming;
      repeat (1600) @(posedge clock);
      chk("amp 50", 32'(set_current_scale), 512);
      bus(1'b0, REG_DIM, 0);
      chk("duty 50", 32'(q[10:0]), 512);
      pwm_high <= 16'd100;
      repeat (1600) @(posedge clock);
      chk("amp low", 32'(set_current_scale), 256);
      watch(1, 800);
      chk("dim rate", 32'(r), 2);
      chk("dim duty x4", 32'(on >= 634 && on <= 640), 1);
      mode_select <= 1'b0;
      repeat (20) @(posedge clock);
      chk("direct amp", 32'(set_current_scale), 1024);
      watch(1, 1000);
      chk("direct duty", 32'(on >= 196 && on <= 204 && r == 2), 1);
      pwm_period <= 16'd1;
      pwm_high <= 16'd1;
      repeat (20) @(posedge clock);
   endtask : dimming

   task automatic protection;
      chk("lowest string", 32'(feedback_select), 32'h04);
      string_sink_pin_open <= 6'h04;
      overvoltage_sense_trip <= 1'b1;
      watch(0, 4);
      watch(0, 24);
      chk("ovp stop", 32'(r), 0);
      chk("fault low", 32'({fault_flag_oe, fault_flag_out}), 32'h2);
      bus(1'b0, REG_STATUS, 0);
      chk("marked", 32'(q[13:8]), 32'h04);
      chk("excluded", 32'({string_gate[2], feedback_select}), 32'h01);
      overvoltage_sense_trip <= 1'b0;
      watch(0, 40);
      chk("resume", 32'(r > 0 && fault_flag_oe === 1'b0), 1);
      string_sink_pin_open <= 6'h00;
      repeat (10) @(posedge clock);
      chk("reconnect", 32'(string_gate[2]), 1);
      overvoltage_sense_above_short <= 1'b0;
      watch(0, 4);
      watch(0, 24);
      chk("short output", 32'(r), 0);
      overvoltage_sense_above_short <= 1'b1;
      string_sink_pin_short <= 6'h02;
      repeat (15900) @(posedge clock);
      chk("short early", 32'(string_gate[1]), 1);
      repeat (300) @(posedge clock);
      bus(1'b0, REG_STATUS, 0);
      chk("short off", 32'({string_gate[1], q[21:16]}), 32'h02);
      string_sink_pin_short <= 6'h00;
      repeat (10) @(posedge clock);
      chk("short clear", 32'(string_gate[1]), 1);
   endtask : protection

   task automatic latch_and_heat;
      string_sink_pin_open <= 6'h3F;
      overvoltage_sense_trip <= 1'b1;
      wait_state(3'h4);
      overvoltage_sense_trip <= 1'b0;
      string_sink_pin_open <= 6'h00;
      repeat (40) @(posedge clock);
      wait_state(3'h4);
      enable_in <= 1'b0;
      wait_state(3'h0);
      enable_in <= 1'b1;
      wait_state(3'h3);
      temp_above_high <= 1'b1;
      temp_above_low <= 1'b1;
      wait_state(3'h0);
      temp_above_high <= 1'b0;
      repeat (40) @(posedge clock);
      wait_state(3'h0);
      temp_above_low <= 1'b0;
      wait_state(3'h3);
   endtask : latch_and_heat

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      startup;
      switching;
      dimming;
      protection;
      latch_and_heat;
      stop_test;
   end
endmodule : tb_top
